// file: common/timer_pkg.sv
// Constants shared by the dual timer and external interrupt block.
// Assumes a 32-bit APB slave with word-aligned registers.
`default_nettype none
package timer_pkg;

  localparam int APB_AW = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER_CONTROL   = 8'h88;
  localparam logic [7:0] IDX_TIMER_MODE      = 8'h89;
  localparam logic [7:0] IDX_TIMER0_LOW_BYTE = 8'h8a;
  localparam logic [7:0] IDX_TIMER1_LOW_BYTE = 8'h8b;
  localparam logic [7:0] IDX_TIMER0_HIGH_BYTE = 8'h8c;
  localparam logic [7:0] IDX_TIMER1_HIGH_BYTE = 8'h8d;
  localparam logic [7:0] IDX_IRQ_STATUS      = 8'ha0;
  localparam logic [7:0] IDX_IRQ_ENABLE      = 8'ha1;
  localparam logic [7:0] IDX_IRQ_CLEAR       = 8'ha2;
  localparam logic [7:0] IDX_EXT_ENABLE      = 8'ha3;

  // Timer control bit positions
  localparam int OVF1_BIT   = 7;
  localparam int RUN1_BIT   = 6;
  localparam int OVF0_BIT   = 5;
  localparam int RUN0_BIT   = 4;
  localparam int XFLAG1_BIT = 3;
  localparam int XTYPE1_BIT = 2;
  localparam int XFLAG0_BIT = 1;
  localparam int XTYPE0_BIT = 0;

  // Timer mode field positions
  localparam int PGATE1_BIT = 7;
  localparam int CT1_BIT    = 6;
  localparam int MODE1_LSB  = 4;
  localparam int PGATE0_BIT = 3;
  localparam int CT0_BIT    = 2;
  localparam int MODE0_LSB  = 0;

  // Interrupt status bit positions
  localparam int EV_OVF0 = 0;
  localparam int EV_OVF1 = 1;
  localparam int EV_XL0  = 2;
  localparam int EV_XL1  = 3;
  localparam int EV_N    = 4;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_EV   = 4'h0;

  // Timer clock is the system clock divided by this many cycles
  localparam int TIMER_DIV_CYCLES = 2;

  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } timer_mode_e;

endpackage
`default_nettype wire

// file: verilog/dual_timer_ext_irq.sv
// Two timer/counters with shared control and mode registers, plus two
// external interrupt lines. Registers sit on APB; pins are asynchronous.
//
// The APB slave port was decided locally.
`default_nettype none
// Overview of operation
// [RULE_01] Timer1 overflow sets flag; vector acknowledge clears
// [RULE_02] Timer0 overflow sets flag; vector acknowledge clears
// [RULE_03] Timer1 ungated runs only with run bit
// [RULE_04] Timer1 gated needs pin high and run
// [RULE_05] Timer0 ungated runs only with run bit
// [RULE_06] Timer0 gated needs pin high and run
// [RULE_07] Timer1 counts clock/2 or count-pin falling edges
// [RULE_08] Timer0 counts clock/2 or count-pin falling edges
// [RULE_09] Timer1 modes: 13-bit, 16-bit, halted
// [RULE_10] Timer1 auto-reload low byte from high byte
// [RULE_11] Timer0 modes: 13-bit and 16-bit
// [RULE_12] Timer0 auto-reload low byte from high byte
// [RULE_13] Timer0 split: high byte uses Timer1 run/flag
// [RULE_14] Line 1 flag set on every falling edge
// [RULE_15] Line 0 flag set on every falling edge
// [RULE_16] Line 1 trigger type: low level or edge
// [RULE_17] Line 0 trigger type: low level or edge
// [RULE_18] Data byte writes load counters; reads return count
module dual_timer_ext_irq
  import timer_pkg::*;
#(
  parameter int TICK_DIV = TIMER_DIV_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  input  wire logic              ext_irq_pin_zero,
  input  wire logic              ext_irq_pin_one,
  input  wire logic              count_input_pin_zero,
  input  wire logic              count_input_pin_one,
  input  wire logic              ack_timer0,
  input  wire logic              ack_timer1,
  input  wire logic              ack_ext0,
  input  wire logic              ack_ext1,
  output logic                   timer0_req,
  output logic                   timer1_req,
  output logic                   ext0_req,
  output logic                   ext1_req,
  output logic                   irq
);

  localparam int DW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

  if (TICK_DIV < 1) begin : bad_div
    $error("TICK_DIV must be at least 1");
  end

  // Decode reads paddr[9:2] and needs a zero field above it
  if (APB_AW < 11) begin : bad_aw
    $error("APB_AW must be at least 11");
  end

  // Event vector is built from exactly four sources
  if (EV_N != 4) begin : bad_ev
    $error("EV_N must be 4");
  end

  // Pin order: 0 count0, 1 count1, 2 irq0, 3 irq1
  logic [3:0] pins_raw;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] sync_prev;
  logic [3:0] pin_fall;

  assign pins_raw = {ext_irq_pin_one, ext_irq_pin_zero, count_input_pin_one, count_input_pin_zero};

  for (genvar i = 0; i < 4; i++) begin : g_sync
    // First stage feeds only the second; edges come from stages two and three
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync_a[i]    <= 1'b1;
        sync_b[i]    <= 1'b1;
        sync_prev[i] <= 1'b1;
      end else if (ce) begin
        sync_a[i]    <= pins_raw[i];
        sync_b[i]    <= sync_a[i];
        sync_prev[i] <= sync_b[i];
      end
    end
    assign pin_fall[i] = sync_prev[i] & ~sync_b[i];
  end

  // Registers
  logic [7:0] timer_control;
  logic [7:0] timer_mode;
  logic [7:0] timer0_low_byte;
  logic [7:0] timer0_high_byte;
  logic [7:0] timer1_low_byte;
  logic [7:0] timer1_high_byte;
  logic [EV_N-1:0] irq_status;
  logic [EV_N-1:0] irq_enable;
  logic [1:0]      ext_enable;
  logic [DW-1:0]   div_cnt;
  logic [31:0]     next_prdata;

  // Control register fields
  wire timer1_overflow_flag    = timer_control[OVF1_BIT];
  wire timer1_run_bit          = timer_control[RUN1_BIT];
  wire timer0_overflow_flag    = timer_control[OVF0_BIT];
  wire timer0_run_bit          = timer_control[RUN0_BIT];
  wire ext_line1_flag          = timer_control[XFLAG1_BIT];
  wire ext_line1_trigger_type  = timer_control[XTYPE1_BIT];
  wire ext_line0_flag          = timer_control[XFLAG0_BIT];
  wire ext_line0_trigger_type  = timer_control[XTYPE0_BIT];

  // Mode register fields
  wire timer1_pin_gating       = timer_mode[PGATE1_BIT];
  wire timer1_count_source_sel = timer_mode[CT1_BIT];
  wire timer0_pin_gating       = timer_mode[PGATE0_BIT];
  wire timer0_count_source_sel = timer_mode[CT0_BIT];
  timer_mode_e timer1_mode_field;
  timer_mode_e timer0_mode_field;
  assign timer1_mode_field = timer_mode_e'(timer_mode[MODE1_LSB+:2]);
  assign timer0_mode_field = timer_mode_e'(timer_mode[MODE0_LSB+:2]);

  // APB decode
  wire [7:0] idx      = paddr[9:2];
  wire       addr_ok  = (paddr[1:0] == 2'b00) && (paddr[APB_AW-1:10] == '0);
  wire       sel_ctl  = addr_ok && (idx == IDX_TIMER_CONTROL);
  wire       sel_mod  = addr_ok && (idx == IDX_TIMER_MODE);
  wire       sel_lo0  = addr_ok && (idx == IDX_TIMER0_LOW_BYTE);
  wire       sel_lo1  = addr_ok && (idx == IDX_TIMER1_LOW_BYTE);
  wire       sel_hi0  = addr_ok && (idx == IDX_TIMER0_HIGH_BYTE);
  wire       sel_hi1  = addr_ok && (idx == IDX_TIMER1_HIGH_BYTE);
  wire       sel_sts  = addr_ok && (idx == IDX_IRQ_STATUS);
  wire       sel_ien  = addr_ok && (idx == IDX_IRQ_ENABLE);
  wire       sel_clr  = addr_ok && (idx == IDX_IRQ_CLEAR);
  wire       sel_xen  = addr_ok && (idx == IDX_EXT_ENABLE);

  // Misaligned or unmapped addresses miss and answer with an error
  wire       hit      = sel_ctl | sel_mod | sel_lo0 | sel_lo1 | sel_hi0 | sel_hi1 |
                        sel_sts | sel_ien | sel_clr | sel_xen;
  wire       access   = psel & penable & ce;

  // Read data is loaded in the setup cycle, so the access needs no wait
  wire       rd_setup = psel & ~penable & ce;

  // Only the low byte lane carries register data
  wire       wr_en    = access & pwrite & hit & pstrb[0];
  wire       wr_ctl   = wr_en & sel_ctl;
  wire       wr_mod   = wr_en & sel_mod;
  wire       wr_lo0   = wr_en & sel_lo0;
  wire       wr_lo1   = wr_en & sel_lo1;
  wire       wr_hi0   = wr_en & sel_hi0;
  wire       wr_hi1   = wr_en & sel_hi1;

  // Status is read-only; a write there is accepted and dropped
  wire       wr_ien   = wr_en & sel_ien;
  wire       wr_clr   = wr_en & sel_clr;
  wire       wr_xen   = wr_en & sel_xen;
  wire [7:0] wbyte    = pwdata[7:0];

  // Zero wait states; frozen clock enable stretches the access
  assign pready  = ce;
  assign pslverr = psel & penable & ~hit;

  // Read data, captured in the setup cycle
  // The write-only clear register falls through and reads as zero
  assign next_prdata = sel_ctl ? {24'h00_0000, timer_control} :
                       sel_mod ? {24'h00_0000, timer_mode} :
                       sel_lo0 ? {24'h00_0000, timer0_low_byte} : // RULE_18
                       sel_lo1 ? {24'h00_0000, timer1_low_byte} : // RULE_18
                       sel_hi0 ? {24'h00_0000, timer0_high_byte} :
                       sel_hi1 ? {24'h00_0000, timer1_high_byte} :
                       sel_sts  ? {28'h000_0000, irq_status} :
                       sel_ien  ? {28'h000_0000, irq_enable} :
                       sel_xen  ? {30'h0000_0000, ext_enable} :
                       32'h0000_0000;

  // Divide-by-two tick of the system clock
  wire tick = (div_cnt == DW'(TICK_DIV - 1));

  // Run conditions
  wire run0 = timer0_run_bit & (~timer0_pin_gating | sync_b[2]); // RULE_05 RULE_06
  wire run1 = timer1_run_bit & (~timer1_pin_gating | sync_b[3]); // RULE_03 RULE_04
  wire src0 = timer0_count_source_sel ? pin_fall[0] : tick;      // RULE_08
  wire src1 = timer1_count_source_sel ? pin_fall[1] : tick;      // RULE_07
  wire inc0 = run0 & src0;
  wire inc1 = run1 & src1 & (timer1_mode_field != MODE_SPLIT);   // RULE_09
  wire split0 = (timer0_mode_field == MODE_SPLIT);
  // Split high byte counts the divided clock under Timer1's run bit
  wire inc0h = split0 & timer1_run_bit & tick;                   // RULE_13

  // Returns {overflow, high, low} after one count
  function automatic logic [16:0] step(input timer_mode_e m,
                                       input logic [7:0] hi,
                                       input logic [7:0] lo);
    logic [5:0]  p;
    logic [8:0]  s;
    logic [16:0] r;
    p = 6'h00;
    s = 9'h000;
    r = {1'b0, hi, lo};
    unique case (m)
      MODE_13BIT: begin
        // Five-bit prescaler in lo carries into hi; lo[7:5] kept
        p = {1'b0, lo[4:0]} + 6'h01;
        s = {1'b0, hi} + {8'h00, p[5]};
        r = {s[8], s[7:0], lo[7:5], p[4:0]};
      end
      MODE_16BIT: begin
        r = {1'b0, hi, lo} + 17'h0_0001;
      end
      MODE_RELOAD: begin
        // The count that wraps loads hi instead of zero
        s = {1'b0, lo} + 9'h001;
        r = s[8] ? {1'b1, hi, hi} : {1'b0, hi, s[7:0]};
      end
      MODE_SPLIT: begin
        // hi belongs to the separate split high-byte counter
        s = {1'b0, lo} + 9'h001;
        r = {s[8], hi, s[7:0]};
      end
    endcase
    return r;
  endfunction

  wire [16:0] step0  = step(timer0_mode_field, timer0_high_byte, timer0_low_byte); // RULE_11 RULE_12
  wire [16:0] step1  = step(timer1_mode_field, timer1_high_byte, timer1_low_byte); // RULE_09 RULE_10
  wire [8:0]  step0h = {1'b0, timer0_high_byte} + 9'h001;

  wire ovf0  = inc0 & step0[16];
  wire ovf0h = inc0h & step0h[8];
  // Timer1 gives up its flag while Timer0 is split
  wire ovf1  = inc1 & step1[16] & ~split0;

  // Line flags catch every falling edge, whatever the trigger type
  wire set_ovf0 = ovf0;            // RULE_02
  wire set_ovf1 = ovf1 | ovf0h;    // RULE_01 RULE_13
  wire set_xl0  = pin_fall[2];     // RULE_15
  wire set_xl1  = pin_fall[3];     // RULE_14

  // Counter next values; a software write wins over counting
  logic [7:0] next_lo0;
  logic [7:0] next_hi0;
  logic [7:0] next_lo1;
  logic [7:0] next_hi1;

  always_comb begin
    next_lo0 = inc0 ? step0[7:0] : timer0_low_byte;
    next_hi0 = (inc0 & ~split0) ? step0[15:8] : timer0_high_byte;
    if (inc0h) begin
      next_hi0 = step0h[7:0];
    end
    next_lo1 = inc1 ? step1[7:0] : timer1_low_byte;
    next_hi1 = inc1 ? step1[15:8] : timer1_high_byte;

    // A load drops the count of that cycle; counting resumes after it
    if (wr_lo0) begin
      next_lo0 = wbyte; // RULE_18
    end
    if (wr_hi0) begin
      next_hi0 = wbyte; // RULE_18
    end
    if (wr_lo1) begin
      next_lo1 = wbyte; // RULE_18
    end
    if (wr_hi1) begin
      next_hi1 = wbyte; // RULE_18
    end
  end

  // Control next value; hardware set beats software or vector clear
  logic [7:0] next_ctl;
  logic [7:0] base_ctl;

  always_comb begin
    base_ctl = wr_ctl ? wbyte : timer_control;

    // Taking a vector clears only the flag it serves
    if (ack_timer1) begin
      base_ctl[OVF1_BIT] = 1'b0;
    end
    if (ack_timer0) begin
      base_ctl[OVF0_BIT] = 1'b0;
    end
    if (ack_ext1) begin
      base_ctl[XFLAG1_BIT] = 1'b0;
    end
    if (ack_ext0) begin
      base_ctl[XFLAG0_BIT] = 1'b0;
    end

    // An event landing with a clear must not be lost
    next_ctl = base_ctl;
    next_ctl[OVF1_BIT]   = base_ctl[OVF1_BIT] | set_ovf1;   // RULE_01
    next_ctl[OVF0_BIT]   = base_ctl[OVF0_BIT] | set_ovf0;   // RULE_02
    next_ctl[XFLAG1_BIT] = base_ctl[XFLAG1_BIT] | set_xl1; // RULE_14
    next_ctl[XFLAG0_BIT] = base_ctl[XFLAG0_BIT] | set_xl0; // RULE_15
  end

  // Sticky status, write-one-to-clear; new events win
  wire [EV_N-1:0] events = {set_xl1, set_xl0, set_ovf1, set_ovf0};
  wire [EV_N-1:0] clr_mask = wr_clr ? pwdata[EV_N-1:0] : {EV_N{1'b0}};
  wire [EV_N-1:0] next_status = events | (irq_status & ~clr_mask);

  // Free-running divider; both timers share one tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (ce) begin
      div_cnt <= tick ? '0 : div_cnt + DW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control    <= RST_BYTE;
      timer_mode       <= RST_BYTE;
      timer0_low_byte  <= RST_BYTE;
      timer0_high_byte <= RST_BYTE;
      timer1_low_byte  <= RST_BYTE;
      timer1_high_byte <= RST_BYTE;
    end else if (ce) begin
      timer_control    <= next_ctl;
      timer_mode       <= wr_mod ? wbyte : timer_mode;
      timer0_low_byte  <= next_lo0;
      timer0_high_byte <= next_hi0;
      timer1_low_byte  <= next_lo1;
      timer1_high_byte <= next_hi1;
    end
  end

  // Enables are plain storage; the irq output is formed below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= RST_EV;
      irq_enable <= RST_EV;
      ext_enable <= 2'b00;
    end else if (ce) begin
      irq_status <= next_status;
      irq_enable <= wr_ien ? wbyte[EV_N-1:0] : irq_enable;
      ext_enable <= wr_xen ? wbyte[1:0] : ext_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      // Held through the access phase and until the next setup
      prdata <= next_prdata;
    end
  end

  // Requests toward the interrupt controller
  // Overflow flags map straight onto their requests
  assign timer0_req = timer0_overflow_flag;
  assign timer1_req = timer1_overflow_flag;

  // Level mode follows the synchronised pin, edge mode the flag
  assign ext0_req = ext_enable[0] &
                    (ext_line0_trigger_type ? ext_line0_flag : ~sync_b[2]); // RULE_17
  assign ext1_req = ext_enable[1] &
                    (ext_line1_trigger_type ? ext_line1_flag : ~sync_b[3]); // RULE_16
  assign irq = |(irq_status & irq_enable);

endmodule
`default_nettype wire

// file: sim/timer_checker_assertions.sv
// Port-level checks for the dual timer block.
// Assumes one clock pclk and async active-low presetn.
`default_nettype none
module timer_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        ack_timer0,
  input wire logic        ack_timer1,
  input wire logic        ext_irq_pin_zero,
  input wire logic        timer0_req,
  input wire logic        timer1_req,
  input wire logic        ext0_req
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic wr_hit = psel && penable && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd; psel && penable && !pwrite; endsequence
  property p_ready; pready == ce; endproperty
  a_ready: assert property (p_ready) else $error("pready differs from ce");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_rd_hold; $changed(prdata) |-> $past(psel && !penable && ce); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_upper; s_rd ##0 pready |-> prdata[31:8] == 24'h00_0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_unmapped; s_rd ##0 pslverr |-> prdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
  property p_flag0_clear; $fell(timer0_req) |-> $past(ack_timer0 || wr_hit); endproperty
  a_flag0_clear: assert property (p_flag0_clear) else $error("timer0 flag lost");
  property p_flag1_clear; $fell(timer1_req) |-> $past(ack_timer1 || wr_hit); endproperty
  a_flag1_clear: assert property (p_flag1_clear) else $error("timer1 flag lost");
  property p_ext0_rise;
    $rose(ext0_req) |-> $past(!ext_irq_pin_zero, 2) || $past(!ext_irq_pin_zero, 3) || $past(wr_hit);
  endproperty
  a_ext0_rise: assert property (p_ext0_rise) else $error("line0 request unprompted");
endmodule
bind dual_timer_ext_irq timer_checker timer_checker_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .ack_timer0(ack_timer0), .ack_timer1(ack_timer1), .ext_irq_pin_zero(ext_irq_pin_zero),
  .timer0_req(timer0_req), .timer1_req(timer1_req), .ext0_req(ext0_req));
`default_nettype wire

// file: sim/pin_source.sv
// Far-side pins: two count inputs and two interrupt inputs, idle high.
// Assumes tasks are called from the pclk domain.
`default_nettype none
module pin_source (
  input  wire logic pclk,
  output logic      ext_irq_pin_zero,
  output logic      ext_irq_pin_one,
  output logic      count_input_pin_zero,
  output logic      count_input_pin_one
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_irq_pin_zero     = 1'b1;
    ext_irq_pin_one      = 1'b1;
    count_input_pin_zero = 1'b1;
    count_input_pin_one  = 1'b1;
  end
  task automatic set_ext(input int l, input logic v);
    @(posedge pclk);
    if (l) ext_irq_pin_one <= v;
    else ext_irq_pin_zero <= v;
  endtask
  // Low two cycles, high three, so the synchroniser sees every edge
  task automatic pulse_count(input int t, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (t) count_input_pin_one <= 1'b0;
      else count_input_pin_zero <= 1'b0;
      repeat (2) @(posedge pclk);
      if (t) count_input_pin_one <= 1'b1;
      else count_input_pin_zero <= 1'b1;
      repeat (2) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench: APB traffic, pin pulses, random counter loads.
// Assumes pin_source on the far side and the bound checker.
`default_nettype none
module testbench
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, serr, irq;
  logic              t0r, t1r, e0r, e1r;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        ack;
  wire logic         ep0, ep1, cp0, cp1;
  int                mismatches, compares, seed, k;
  logic [7:0]        regs [8] = '{IDX_TIMER_CONTROL, IDX_TIMER_MODE, IDX_TIMER0_LOW_BYTE, IDX_TIMER1_LOW_BYTE,
                                  IDX_TIMER0_HIGH_BYTE, IDX_TIMER1_HIGH_BYTE, IDX_IRQ_STATUS, IDX_IRQ_CLEAR};
  dual_timer_ext_irq dual_timer_ext_irq_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .ext_irq_pin_zero(ep0), .ext_irq_pin_one(ep1),
    .count_input_pin_zero(cp0), .count_input_pin_one(cp1), .ack_timer0(ack[0]), .ack_timer1(ack[1]),
    .ack_ext0(ack[2]), .ack_ext1(ack[3]), .timer0_req(t0r), .timer1_req(t1r), .ext0_req(e0r),
    .ext1_req(e1r), .irq(irq));
  pin_source pin_source_i (.pclk(pclk), .ext_irq_pin_zero(ep0), .ext_irq_pin_one(ep1),
    .count_input_pin_zero(cp0), .count_input_pin_one(cp1));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic complete_run();
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic timeout();
    mismatches++;
    complete_run();
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Ends on the falling edge so callers sample settled outputs
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd      = prdata;
    serr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) timeout();
    @(negedge pclk);
  endtask
  task automatic pulse_ack(input int b);
    @(posedge pclk);
    ack <= 4'(1 << b);
    @(posedge pclk);
    ack <= 4'h0;
    @(negedge pclk);
  endtask
  // Returns {overflow, high byte, low byte} after n counts
  function automatic logic [16:0] model(input int t, md, n, input logic [7:0] tl, th);
    logic [16:0] c;
    logic        ov;
    ov = 1'b0;
    case (md)
      0: begin
        c = {4'h0, th, tl[4:0]} + 17'(n);
        return {c[13], c[12:5], tl[7:5], c[4:0]};
      end
      1: return 17'({th, tl}) + 17'(n);
      2: begin
        for (int i = 0; i < n; i++) begin
          ov |= (tl == 8'hff);
          tl = (tl == 8'hff) ? th : tl + 8'h01;
        end
        return {ov, th, tl};
      end
      default: begin
        c = {9'h000, tl} + 17'(n * (1 - t));
        return {c[8], th, c[7:0]};
      end
    endcase
  endfunction
  task automatic run(input int t, md, g);
    logic [7:0]  tl, th, lo, hi;
    logic [16:0] e;
    int          n;
    n  = 1 + ($unsigned($random(seed)) % 6);
    tl = 8'hfc | 8'($random(seed) & 3);
    th = ($random(seed) & 1) ? 8'hff : 8'($random(seed));
    lo = t ? IDX_TIMER1_LOW_BYTE : IDX_TIMER0_LOW_BYTE;
    hi = t ? IDX_TIMER1_HIGH_BYTE : IDX_TIMER0_HIGH_BYTE;
    e  = model(t, md, g ? 0 : n, tl, th);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h00);
    apb(1'b1, IDX_TIMER_MODE, 8'((g * 8 + 4 + md) << (4 * t)));
    apb(1'b1, lo, tl);
    apb(1'b1, hi, th);
    if (g) pin_source_i.set_ext(t, 1'b0);
    apb(1'b1, IDX_TIMER_CONTROL, 8'(16 << (2 * t)));
    pin_source_i.pulse_count(t, n);
    repeat (5) @(posedge pclk);
    check("overflow", 32'(t ? t1r : t0r), 32'(e[16]));
    pulse_ack(t);
    check("flag after ack", 32'(t ? t1r : t0r), 32'h0000_0000);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h00);
    apb(1'b0, lo, 8'h00);
    check("low byte", rd, 32'(e[7:0]));
    apb(1'b0, hi, 8'h00);
    check("high byte", rd, 32'(e[15:8]));
    if (g) pin_source_i.set_ext(t, 1'b1);
  endtask
  initial begin
    seed    = 32'h8759;
    presetn = 1'b0;
    ce      = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    ack     = 4'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 8'h00);
      check("reset value", rd, 32'h0000_0000);
    end
    apb(1'b0, 8'h40, 8'h00);
    check("unmapped error", 32'(serr), 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    ce <= 1'b0;
    repeat (2) @(posedge pclk);
    check("frozen pready", 32'(pready), 32'h0000_0000);
    ce <= 1'b1;
    for (int t = 0; t < 2; t++)
      for (int m = 0; m < 8; m++)
        run(t, m % 4, m / 4);
    // Split mode: upper byte of timer0 runs on timer1's run bit and flag
    apb(1'b1, IDX_TIMER_MODE, 8'h03);
    apb(1'b1, IDX_TIMER0_HIGH_BYTE, 8'hfe);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h40);
    for (k = 0; k < 20 && t1r !== 1'b1; k++) @(posedge pclk);
    if (k >= 20) timeout();
    check("split flag", 32'(t0r), 32'h0000_0000);
    pulse_ack(1);
    check("split ack", 32'(t1r), 32'h0000_0000);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h00);
    apb(1'b1, IDX_TIMER_MODE, 8'h10);
    apb(1'b1, IDX_TIMER1_LOW_BYTE, 8'h00);
    apb(1'b1, IDX_TIMER1_HIGH_BYTE, 8'h00);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h40);
    repeat (37) @(posedge pclk);
    apb(1'b1, IDX_TIMER_CONTROL, 8'h00);
    apb(1'b0, IDX_TIMER1_LOW_BYTE, 8'h00);
    check("clock rate", 32'(rd >= 19 && rd <= 21), 32'h0000_0001);
    apb(1'b1, IDX_EXT_ENABLE, 8'h03);
    apb(1'b1, IDX_IRQ_ENABLE, 8'h0f);
    for (int l = 0; l < 2; l++)
      for (int it = 0; it < 2; it++) begin
        apb(1'b1, IDX_TIMER_CONTROL, 8'(it << (2 * l)));
        apb(1'b1, IDX_IRQ_CLEAR, 8'h0f);
        pin_source_i.set_ext(l, 1'b0);
        repeat (5) @(posedge pclk);
        check("line low", 32'(l ? e1r : e0r), 32'h0000_0001);
        pin_source_i.set_ext(l, 1'b1);
        repeat (5) @(posedge pclk);
        check("line released", 32'(l ? e1r : e0r), 32'(it));
        apb(1'b0, IDX_IRQ_STATUS, 8'h00);
        check("status", rd, 32'(4 << l));
        check("irq", 32'(irq), 32'h0000_0001);
        pulse_ack(2 + l);
        apb(1'b0, IDX_TIMER_CONTROL, 8'h00);
        check("flag after ack", rd, 32'(it << (2 * l)));
      end
    apb(1'b1, IDX_IRQ_ENABLE, 8'h00);
    check("irq masked", 32'(irq), 32'h0000_0000);
    complete_run();
  end
endmodule
`default_nettype wire
